// file: hw/afe_byte_reg.sv
// Purpose: One byte-wide control register with a write strobe
// Assumes: Reset value is a constant parameter
// Notes:   All bits are stored, including bits with no function
`timescale 1ns/10ps
module afe_byte_reg #(
  parameter int         WIDTH     = 8,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic             clock,   // System clock
  input  wire logic             nrst,    // Async reset, active low
  input  wire logic             wr_hit,  // Write this register
  input  wire logic [WIDTH-1:0] wr_data, // Byte to store
  output logic      [WIDTH-1:0] value    // Stored byte
);

  logic [WIDTH-1:0] value_q;
  logic [WIDTH-1:0] value_d;

  always_comb begin
    value_d = value_q;
    if (wr_hit) begin
      value_d = wr_data;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      value_q <= RESET_VAL[WIDTH-1:0];
    end else begin
      value_q <= value_d;
    end
  end

  assign value = value_q;

endmodule

// file: hw/afe_ctrl_pkg.sv
// Purpose: Shared constants and types for the analog front end control bank
// Assumes: Byte-wide register port, addresses equal to the register offsets
// Notes:   Every offset, field position, reset value and decode figure lives here
package afe_ctrl_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [7:0] ADDR_CONVERTER_CODE     = 8'h00;
  localparam logic [7:0] ADDR_AMP_GAIN_MODE      = 8'h01;
  localparam logic [7:0] ADDR_CONVERTER_REF_SEL  = 8'h03;
  localparam logic [7:0] ADDR_CHANNEL_AND_POWER  = 8'h04;
  localparam logic [7:0] ADDR_OFFSET_SWITCHES    = 8'h06;

  // Reset values
  localparam logic [7:0] RST_CONVERTER_CODE      = 8'h80;
  localparam logic [7:0] RST_AMP_GAIN_MODE       = 8'h00;
  localparam logic [7:0] RST_CONVERTER_REF_SEL   = 8'h00;
  localparam logic [7:0] RST_CHANNEL_AND_POWER   = 8'h00;
  localparam logic [7:0] RST_OFFSET_SWITCHES     = 8'h00;
  localparam logic [7:0] UNMAPPED_READ           = 8'h00;

  // amp_gain_mode fields
  localparam int INPUT_MODE_BIT  = 7;
  localparam int SPEED_HI_BIT    = 6;
  localparam int SPEED_LO_BIT    = 5;
  localparam int GAIN_MSB        = 3;
  localparam int GAIN_LSB        = 0;

  // channel_and_power fields
  localparam int PAIR_HI_BIT     = 7;
  localparam int PAIR_LO_BIT     = 6;
  localparam int AMP_PWR_BIT     = 3;
  localparam int CONV_PWR_BIT    = 2;
  localparam int REG_PWR_BIT     = 1;
  localparam int TEMP_PWR_BIT    = 0;

  // offset_switches and converter_reference_select fields
  localparam int SWITCH_B_BIT    = 1;
  localparam int SWITCH_A_BIT    = 0;
  localparam int REF_HI_BIT      = 1;
  localparam int REF_LO_BIT      = 0;

  // Gain decode: base plus step per code, top code barred
  localparam logic [5:0] GAIN_BASE_DB    = 6'h06;
  localparam logic [5:0] GAIN_STEP_DB    = 6'h02;
  localparam logic [3:0] GAIN_BARRED     = 4'hf;

  // Reference ceiling in fifths of the analog supply
  localparam logic [2:0] CEIL_FULL_FIFTHS  = 3'h5;
  localparam logic [2:0] CEIL_FOUR_FIFTHS  = 3'h4;
  localparam logic [2:0] CEIL_THREE_FIFTHS = 3'h3;
  localparam int         LEVEL_STEPS       = 256;
  localparam int         SCALED_W          = 11;

  typedef enum logic [1:0] {
    SPEED_HIGH = 2'b00,
    SPEED_MID2 = 2'b01,
    SPEED_MID1 = 2'b10,
    SPEED_LOW  = 2'b11
  } speed_type;

  typedef enum logic [1:0] {
    PAIR_0    = 2'b00,
    PAIR_1    = 2'b01,
    PAIR_2    = 2'b10,
    PAIR_OPEN = 2'b11
  } pair_type;

  typedef enum logic [1:0] {
    CEIL_SUPPLY      = 2'b00,
    CEIL_FOUR_FIFTH  = 2'b01,
    CEIL_THREE_FIFTH = 2'b10,
    CEIL_SUPPLY_ALT  = 2'b11
  } ceiling_type;

endpackage

// file: hw/analog_frontend_control_regs.sv
// Purpose: Control register bank for the amplifier, converter and power enables
// Assumes: Serial front end delivers decoded byte writes and reads on this port
// Notes:   Analog controls follow the stored bytes in the cycle after a write
//
// How it works
// - Gain is 6 dB plus 2 dB per code
// - Bit 7 picks rail-to-rail or single-ended input
// - Bits 6:5 pick one of four speed modes
// - Reset loads level 80h, others 00h
// - Bit 4 of gain register stored, no effect
// - Bits 7:6 route pair 0, 1, 2 or open
// - Bit 3 powers the amplifier
// - Bit 2 powers the converter
// - Bit 1 regulator, bit 0 sensor power
// - Power register bits 5:4 stored, no effect
// - Switch bits close offset switches when set
// - Upper switch and reference bits stored, unused
// - Converter output is ceiling times level over 256
// - Ceiling is full, four fifths or three fifths
`timescale 1ns/10ps
module analog_frontend_control_regs #(
  parameter int ADDR_W = afe_ctrl_pkg::ADDR_W,
  parameter int DATA_W = afe_ctrl_pkg::DATA_W
) (
  input  wire logic                  clock,                 // 25 MHz clock
  input  wire logic                  nrst,                  // Async reset, active low
  input  wire logic                  wr_en,                 // Write strobe, one cycle
  input  wire logic [ADDR_W-1:0]     wr_addr,               // Write register offset
  input  wire logic [DATA_W-1:0]     wr_data,               // Write byte
  input  wire logic                  rd_en,                 // Read strobe, one cycle
  input  wire logic [ADDR_W-1:0]     rd_addr,               // Read register offset
  output logic      [DATA_W-1:0]     rd_data,               // Read byte, registered
  output logic                       rd_valid,              // Read data valid pulse
  output logic      [3:0]            gain_code,             // Amplifier gain code
  output logic      [5:0]            gain_db,               // Decoded gain in dB
  output logic                       gain_barred,           // Prohibited gain code held
  output logic                       input_mode_select,     // 1 single-ended, 0 rail-to-rail
  output afe_ctrl_pkg::speed_type    speed_mode,            // Amplifier speed mode
  output logic      [2:0]            pair_route,            // One-hot input pair select
  output logic                       input_open,            // Amplifier input left open
  output logic                       amp_power_on,          // Amplifier enable
  output logic                       converter_power_on,    // Converter enable
  output logic                       regulator_power_on,    // Regulator enable
  output logic                       temp_sensor_power_on,  // Sensor enable
  output logic                       offset_switch_a,       // Offset switch A closed
  output logic                       offset_switch_b,       // Offset switch B closed
  output logic      [7:0]            converter_level,       // Converter code m
  output logic      [2:0]            ceiling_fifths,        // Ceiling in fifths of supply
  output logic      [10:0]           converter_scaled,      // m times fifths, supply/1280
  output logic                       switch_order_fault     // Switch closed with input routed
);

  logic [DATA_W-1:0] code_val;
  logic [DATA_W-1:0] gain_val;
  logic [DATA_W-1:0] ref_val;
  logic [DATA_W-1:0] power_val;
  logic [DATA_W-1:0] switch_val;
  logic              hit_code;
  logic              hit_gain;
  logic              hit_ref;
  logic              hit_power;
  logic              hit_switch;
  logic [DATA_W-1:0] rd_data_q;
  logic [DATA_W-1:0] rd_data_d;
  logic              rd_valid_q;
  logic              rd_valid_d;
  logic              fault_q;
  logic              fault_d;

  // Write decode; unmapped offsets are ignored
  always_comb begin
    hit_code   = wr_en && (wr_addr == afe_ctrl_pkg::ADDR_CONVERTER_CODE);
    hit_gain   = wr_en && (wr_addr == afe_ctrl_pkg::ADDR_AMP_GAIN_MODE);
    hit_ref    = wr_en && (wr_addr == afe_ctrl_pkg::ADDR_CONVERTER_REF_SEL);
    hit_power  = wr_en && (wr_addr == afe_ctrl_pkg::ADDR_CHANNEL_AND_POWER);
    hit_switch = wr_en && (wr_addr == afe_ctrl_pkg::ADDR_OFFSET_SWITCHES);
  end

  // Whole bytes stored, spare bits included
  afe_byte_reg #(.WIDTH(DATA_W), .RESET_VAL(afe_ctrl_pkg::RST_CONVERTER_CODE)) u_code (
    .clock   (clock),
    .nrst    (nrst),
    .wr_hit  (hit_code),
    .wr_data (wr_data),
    .value   (code_val)
  );

  afe_byte_reg #(.WIDTH(DATA_W), .RESET_VAL(afe_ctrl_pkg::RST_AMP_GAIN_MODE)) u_gain (
    .clock   (clock),
    .nrst    (nrst),
    .wr_hit  (hit_gain),
    .wr_data (wr_data),
    .value   (gain_val)
  );

  afe_byte_reg #(.WIDTH(DATA_W), .RESET_VAL(afe_ctrl_pkg::RST_CONVERTER_REF_SEL)) u_ref (
    .clock   (clock),
    .nrst    (nrst),
    .wr_hit  (hit_ref),
    .wr_data (wr_data),
    .value   (ref_val)
  );

  afe_byte_reg #(.WIDTH(DATA_W), .RESET_VAL(afe_ctrl_pkg::RST_CHANNEL_AND_POWER)) u_power (
    .clock   (clock),
    .nrst    (nrst),
    .wr_hit  (hit_power),
    .wr_data (wr_data),
    .value   (power_val)
  );

  afe_byte_reg #(.WIDTH(DATA_W), .RESET_VAL(afe_ctrl_pkg::RST_OFFSET_SWITCHES)) u_switch (
    .clock   (clock),
    .nrst    (nrst),
    .wr_hit  (hit_switch),
    .wr_data (wr_data),
    .value   (switch_val)
  );

  // Amplifier decode
  always_comb begin
    gain_code = gain_val[afe_ctrl_pkg::GAIN_MSB:afe_ctrl_pkg::GAIN_LSB];
    gain_db   = afe_ctrl_pkg::GAIN_BASE_DB
              + 6'(afe_ctrl_pkg::GAIN_STEP_DB * {2'h0, gain_code});
    gain_barred       = (gain_code == afe_ctrl_pkg::GAIN_BARRED);
    input_mode_select = gain_val[afe_ctrl_pkg::INPUT_MODE_BIT];
    speed_mode        = afe_ctrl_pkg::speed_type'({gain_val[afe_ctrl_pkg::SPEED_HI_BIT],
                                                   gain_val[afe_ctrl_pkg::SPEED_LO_BIT]});
  end

  // Input pair routing and power enables
  always_comb begin
    pair_route = 3'h0;
    input_open = 1'b0;
    unique case (afe_ctrl_pkg::pair_type'({power_val[afe_ctrl_pkg::PAIR_HI_BIT],
                                           power_val[afe_ctrl_pkg::PAIR_LO_BIT]}))
      afe_ctrl_pkg::PAIR_0: begin
        pair_route = 3'h1;
      end
      afe_ctrl_pkg::PAIR_1: begin
        pair_route = 3'h2;
      end
      afe_ctrl_pkg::PAIR_2: begin
        pair_route = 3'h4;
      end
      afe_ctrl_pkg::PAIR_OPEN: begin
        input_open = 1'b1;
      end
    endcase
    amp_power_on         = power_val[afe_ctrl_pkg::AMP_PWR_BIT];
    converter_power_on   = power_val[afe_ctrl_pkg::CONV_PWR_BIT];
    regulator_power_on   = power_val[afe_ctrl_pkg::REG_PWR_BIT];
    temp_sensor_power_on = power_val[afe_ctrl_pkg::TEMP_PWR_BIT];
    offset_switch_a      = switch_val[afe_ctrl_pkg::SWITCH_A_BIT];
    offset_switch_b      = switch_val[afe_ctrl_pkg::SWITCH_B_BIT];
  end

  // Converter ceiling and scaled level
  always_comb begin
    ceiling_fifths = afe_ctrl_pkg::CEIL_FULL_FIFTHS;
    unique case (afe_ctrl_pkg::ceiling_type'({ref_val[afe_ctrl_pkg::REF_HI_BIT],
                                              ref_val[afe_ctrl_pkg::REF_LO_BIT]}))
      afe_ctrl_pkg::CEIL_SUPPLY: begin
        ceiling_fifths = afe_ctrl_pkg::CEIL_FULL_FIFTHS;
      end
      afe_ctrl_pkg::CEIL_FOUR_FIFTH: begin
        ceiling_fifths = afe_ctrl_pkg::CEIL_FOUR_FIFTHS;
      end
      afe_ctrl_pkg::CEIL_THREE_FIFTH: begin
        ceiling_fifths = afe_ctrl_pkg::CEIL_THREE_FIFTHS;
      end
      afe_ctrl_pkg::CEIL_SUPPLY_ALT: begin
        ceiling_fifths = afe_ctrl_pkg::CEIL_FULL_FIFTHS;
      end
    endcase
    converter_level  = code_val;
    // Units of supply/(5*256): ceiling * m / 256
    converter_scaled = {3'h0, code_val} * {8'h00, ceiling_fifths};
  end

  // Flag a closed offset switch while an input pair is still routed
  always_comb begin
    fault_d = (offset_switch_a || offset_switch_b) && !input_open;
  end

  // Read path; returns whole stored bytes, unmapped offsets read zero
  always_comb begin
    rd_valid_d = rd_en;
    rd_data_d  = rd_data_q;
    if (rd_en) begin
      unique case (rd_addr)
        afe_ctrl_pkg::ADDR_CONVERTER_CODE: begin
          rd_data_d = code_val;
        end
        afe_ctrl_pkg::ADDR_AMP_GAIN_MODE: begin
          rd_data_d = gain_val;
        end
        afe_ctrl_pkg::ADDR_CONVERTER_REF_SEL: begin
          rd_data_d = ref_val;
        end
        afe_ctrl_pkg::ADDR_CHANNEL_AND_POWER: begin
          rd_data_d = power_val;
        end
        afe_ctrl_pkg::ADDR_OFFSET_SWITCHES: begin
          rd_data_d = switch_val;
        end
        default: begin
          rd_data_d = afe_ctrl_pkg::UNMAPPED_READ;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
      fault_q    <= 1'b0;
    end else begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      fault_q    <= fault_d;
    end
  end

  assign rd_data            = rd_data_q;
  assign rd_valid           = rd_valid_q;
  assign switch_order_fault = fault_q;

  // Helper: marks the first cycle after reset release
  logic seen_q;
  logic seen_d;

  always_comb begin
    seen_d = 1'b1;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= seen_d;
    end
  end

  sequence code_write_s;
    wr_en && (wr_addr == afe_ctrl_pkg::ADDR_CONVERTER_CODE);
  endsequence

  sequence switch_write_s;
    wr_en && (wr_addr == afe_ctrl_pkg::ADDR_OFFSET_SWITCHES) && !rd_en;
  endsequence

  sequence switch_read_s;
    rd_en && (rd_addr == afe_ctrl_pkg::ADDR_OFFSET_SWITCHES) && !wr_en;
  endsequence

  reset_values_a: assert property (@(posedge clock) disable iff (!nrst)
    !seen_q |-> (converter_level == 8'h80) && (gain_val == 8'h00) && (ref_val == 8'h00)
                && (power_val == 8'h00) && (switch_val == 8'h00))
    else $error("register bank not at reset values");

  level_update_a: assert property (@(posedge clock) disable iff (!nrst)
    code_write_s |=> (converter_level == $past(wr_data)))
    else $error("converter level did not take written byte");

  level_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    !hit_code |=> $stable(converter_level))
    else $error("converter level changed without a write");

  gain_decode_a: assert property (@(posedge clock) disable iff (!nrst)
    (gain_db == 6'(6 + 2 * gain_code)) && (gain_barred == (gain_code == 4'hf)))
    else $error("gain decode wrong");

  mode_decode_a: assert property (@(posedge clock) disable iff (!nrst)
    hit_gain |=> (speed_mode == $past(wr_data[6:5]))
                 && (input_mode_select == $past(wr_data[7])))
    else $error("speed or input mode decode wrong");

  pair_route_a: assert property (@(posedge clock) disable iff (!nrst)
    hit_power |=> (input_open == ($past(wr_data[7:6]) == 2'b11))
                  && (pair_route == (3'h1 << $past(wr_data[7:6])) % 8))
    else $error("input pair routing wrong");

  power_bits_a: assert property (@(posedge clock) disable iff (!nrst)
    hit_power |=> ({amp_power_on, converter_power_on, regulator_power_on,
                    temp_sensor_power_on} == $past(wr_data[3:0])))
    else $error("power enables do not follow write");

  switch_readback_a: assert property (@(posedge clock) disable iff (!nrst)
    switch_write_s ##1 switch_read_s |=> rd_valid && (rd_data == $past(wr_data, 2))
                                         && (offset_switch_a == $past(wr_data[0], 2)))
    else $error("offset switch byte not read back whole");

  ceiling_scale_a: assert property (@(posedge clock) disable iff (!nrst)
    converter_scaled == {3'h0, converter_level} * ((ref_val[1:0] == 2'b01) ? 11'd4 :
                                                   (ref_val[1:0] == 2'b10) ? 11'd3 : 11'd5))
    else $error("scaled converter output wrong");

  switch_fault_a: assert property (@(posedge clock) disable iff (!nrst)
    (offset_switch_a && !input_open) |=> switch_order_fault)
    else $error("switch order fault not raised");

endmodule

// file: verif/afe_host_model.sv
// Purpose: Host side of the register port, byte writes and reads
// Assumes: Requests change at the falling edge, taken at the rising edge
// Notes:   Released address and data lines show the inverse of the last value
`timescale 1ns/10ps
module afe_host_model (
  input  wire logic       clock,    // Bench clock
  output logic            wr_en,    // Write strobe
  output logic [7:0]      wr_addr,  // Write offset
  output logic [7:0]      wr_data,  // Write byte
  output logic            rd_en,    // Read strobe
  output logic [7:0]      rd_addr,  // Read offset
  input  wire logic [7:0] rd_data,  // Read byte
  input  wire logic       rd_valid  // Read data valid
);
  initial begin
    wr_en   = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    rd_en   = 1'b0;
    rd_addr = 8'h00;
  end

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    wr_en   = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clock);
    wr_en   = 1'b0;
    wr_addr = ~a;
    wr_data = ~d;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clock);
    rd_en   = 1'b1;
    rd_addr = a;
    @(negedge clock);
    rd_en   = 1'b0;
    rd_addr = ~a;
    d       = rd_data;
    v       = rd_valid;
  endtask

  // Power byte: enables set for used functions, converter kept off under outside reference
  function automatic logic [7:0] power_byte(input logic [1:0] pair, input logic amp,
                                            input logic conv, input logic ext_ref);
    power_byte = {pair, 2'b00, amp, conv & ~ext_ref, 2'b00};
  endfunction

  // Open the input before any offset switch closes
  task automatic safe_switches(input logic [7:0] pwr, input logic [7:0] sw);
    write_reg(8'h04, pwr | 8'hc0);
    write_reg(8'h06, sw);
  endtask
endmodule

// file: verif/analog_frontend_control_regs_tb_top.sv
// Purpose: Self-checking bench for the analog front end control bank
// Assumes: Host model drives the register port at the falling edge
// Notes:   Shadow copy of the bank gives every expected output
`timescale 1ns/10ps
module analog_frontend_control_regs_tb_top;
  logic        clock;
  logic        nrst;
  logic        wr_en, rd_en, rd_valid, gain_barred, input_mode_select, input_open;
  logic        amp_power_on, converter_power_on, regulator_power_on, temp_sensor_power_on;
  logic        offset_switch_a, offset_switch_b, switch_order_fault;
  logic [7:0]  wr_addr, wr_data, rd_addr, rd_data, converter_level;
  logic [3:0]  gain_code;
  logic [5:0]  gain_db;
  logic [2:0]  pair_route, ceiling_fifths;
  logic [10:0] converter_scaled;
  afe_ctrl_pkg::speed_type speed_mode;
  int          failures, n_compared;
  logic [31:0] rng;
  logic [7:0]  shadow [0:7];
  logic [7:0]  rd_v;
  logic        vld;
  logic [31:0] r;
  logic [7:0]  a;

  afe_host_model host (.clock(clock), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));

  analog_frontend_control_regs dut (.clock(clock), .nrst(nrst), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .gain_code(gain_code), .gain_db(gain_db),
    .gain_barred(gain_barred), .input_mode_select(input_mode_select),
    .speed_mode(speed_mode), .pair_route(pair_route), .input_open(input_open),
    .amp_power_on(amp_power_on), .converter_power_on(converter_power_on),
    .regulator_power_on(regulator_power_on), .temp_sensor_power_on(temp_sensor_power_on),
    .offset_switch_a(offset_switch_a), .offset_switch_b(offset_switch_b),
    .converter_level(converter_level), .ceiling_fifths(ceiling_fifths),
    .converter_scaled(converter_scaled), .switch_order_fault(switch_order_fault));

  initial clock = 1'b0;
  always #20 clock = ~clock;

  function automatic logic [31:0] next_rand();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  function automatic logic mapped(input logic [7:0] x);
    return x == 8'h00 || x == 8'h01 || x == 8'h03 || x == 8'h04 || x == 8'h06;
  endfunction

  function automatic logic [2:0] exp_fifths(input logic [1:0] c);
    return (c == 2'b01) ? 3'h4 : (c == 2'b10) ? 3'h3 : 3'h5;
  endfunction

  function automatic logic [2:0] exp_pair(input logic [1:0] c);
    return (c == 2'b11) ? 3'h0 : 3'h1 << c;
  endfunction

  task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reset_shadow();
    for (int i = 0; i < 8; i++) shadow[i] = 8'h00;
    shadow[0] = 8'h80;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    host.write_reg(ad, d);
    if (mapped(ad)) shadow[ad[2:0]] = d;
  endtask

  task automatic rd_check(input logic [7:0] ad);
    host.read_reg(ad, rd_v, vld);
    cmp({10'h000, vld}, 11'h001);
    cmp({3'h0, rd_v}, {3'h0, mapped(ad) ? shadow[ad[2:0]] : 8'h00});
  endtask

  task automatic check_all();
    logic [7:0] ag;
    logic [7:0] cp;
    logic [2:0] fi;
    ag = shadow[1];
    cp = shadow[4];
    fi = exp_fifths(shadow[3][1:0]);
    @(negedge clock);
    cmp(11'(gain_code), 11'(ag[3:0]));
    cmp(11'(gain_db), 11'(6'h06 + {1'b0, ag[3:0], 1'b0}));
    cmp(11'(gain_barred), 11'(ag[3:0] == 4'hf));
    cmp(11'(input_mode_select), 11'(ag[7]));
    cmp(11'(speed_mode), 11'(ag[6:5]));
    cmp(11'(pair_route), 11'(exp_pair(cp[7:6])));
    cmp(11'(input_open), 11'(cp[7:6] == 2'b11));
    cmp(11'(amp_power_on), 11'(cp[3]));
    cmp(11'(converter_power_on), 11'(cp[2]));
    cmp(11'({regulator_power_on, temp_sensor_power_on}), 11'(cp[1:0]));
    cmp(11'({offset_switch_b, offset_switch_a}), 11'(shadow[6][1:0]));
    cmp(11'(converter_level), 11'(shadow[0]));
    cmp(11'(ceiling_fifths), 11'(fi));
    cmp(converter_scaled, {3'h0, shadow[0]} * {8'h00, fi});
    cmp(11'(switch_order_fault), 11'(shadow[6][1:0] != 2'b00 && cp[7:6] != 2'b11));
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    results();
  end

  initial begin
    failures = 0;
    n_compared = 0;
    rng = 32'd59776;
    nrst = 1'b0;
    reset_shadow();
    repeat (16) @(negedge clock);
    check_all();
    nrst = 1'b1;
    foreach (shadow[i]) rd_check(8'(i));
    for (int c = 0; c < 16; c++) begin
      r = next_rand();
      wr(8'h01, {r[7:5], 1'b1, 4'(c)});
      check_all();
    end
    wr(8'h00, 8'hff);
    for (int c = 0; c < 4; c++) begin
      wr(8'h03, {6'h3f, 2'(c)});
      check_all();
      rd_check(8'h03);
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h04, {2'(c), 6'h3f});
      check_all();
    end
    wr(8'h04, host.power_byte(2'b00, 1'b1, 1'b1, 1'b1));
    check_all();
    host.safe_switches(8'h0c, 8'hff);
    shadow[4] = 8'hcc;
    shadow[6] = 8'hff;
    check_all();
    wr(8'h04, 8'h0c);
    check_all();
    fork
      wr(8'h06, 8'h00);
      host.read_reg(8'h06, rd_v, vld);
    join
    cmp({3'h0, rd_v}, 11'h0ff);
    check_all();
    // Write then read the switch byte in the very next cycle
    fork
      wr(8'h06, 8'ha5);
      begin
        @(negedge clock);
        host.read_reg(8'h06, rd_v, vld);
      end
    join
    cmp({3'h0, rd_v}, {3'h0, shadow[6]});
    cmp({10'h000, vld}, 11'h001);
    check_all();
    for (int n = 0; n < 300; n++) begin
      r = next_rand();
      a = (r[4:3] == 2'b11) ? r[31:24] : {5'h00, r[2:0]};
      wr(a, r[15:8]);
      check_all();
      rd_check({5'h00, r[22:20]});
    end
    @(negedge clock);
    nrst = 1'b0;
    reset_shadow();
    check_all();
    @(negedge clock);
    nrst = 1'b1;
    rd_check(8'h00);
    results();
  end
endmodule
